/* File: logic/irmc_input_cfg.sv */
// one reference input configuration register with its frequency check
`timescale 1ns/100ps
module irmc_input_cfg
#(
   parameter logic [irmc_pkg::DATA_W-1:0] RESET_VALUE = 8'h00
)
(
   input  wire logic clk_sys,
   input  wire logic rst,
   irmc_reg_if.owner cfgPort
);
   import irmc_pkg::*;

   localparam logic RESET_UNUSED =
      irmcFreqUnused(RESET_VALUE[FREQ_HI:FREQ_LO]);

   logic [DATA_W-1:0] word_r;
   logic [DATA_W-1:0] word_nxt;
   logic              unused_r;
   logic              unused_nxt;

   always_comb
   begin
      word_nxt = word_r;
      if (cfgPort.wrEn)
      begin
         word_nxt = cfgPort.wrData;
      end
      // flag codes that name no frequency
      unused_nxt = irmcFreqUnused(word_nxt[FREQ_HI:FREQ_LO]);
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         word_r   <= RESET_VALUE;
         unused_r <= RESET_UNUSED;
      end
      else
      begin
         word_r   <= word_nxt;
         unused_r <= unused_nxt;
      end
   end

   assign cfgPort.word       = word_r;
   assign cfgPort.freqUnused = unused_r;
endmodule

/* File: logic/irmc_pkg.sv */
// constants and types of the input reference and loop mode configuration
// Operation
// - bit 7 routes input through programmable pre-divider
// - bit 6 selects fixed pre-divider, 8 kHz lock
// - bits 5:4 pick leaky-bucket configuration zero-three
// - bits 3:0 code nominal input frequency
// - reset: inputs 1,2 zero; inputs 3,4 0x03
// - mode field 000 automatic, else forces state; here code 011 forces nothing
// - forced-state codes fixed; 011 unused; force carefully
package irmc_pkg;

   localparam int NUM_INPUTS = 4;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;
   localparam int BUCKET_W   = 2;
   localparam int FREQ_W     = 4;
   localparam int MODE_W     = 3;

   // ******************************************************************
   // register map
   // ******************************************************************
   localparam logic [ADDR_W-1:0] INPUT_CFG_ADDR [NUM_INPUTS] =
      '{8'h22, 8'h23, 8'h27, 8'h28};
   localparam logic [DATA_W-1:0] INPUT_CFG_RESET [NUM_INPUTS] =
      '{8'h00, 8'h00, 8'h03, 8'h03};
   localparam logic [ADDR_W-1:0] LOOP_FORCE_ADDR  = 8'h32;
   localparam logic [MODE_W-1:0] LOOP_FORCE_RESET = 3'h0;
   localparam logic [DATA_W-1:0] UNMAPPED_READ    = 8'h00;

   // ******************************************************************
   // field layout of an input configuration register and of the loop state force register
   // ******************************************************************
   localparam int PREDIV_BIT = 7;
   localparam int LOCK8K_BIT = 6;
   localparam int BUCKET_HI  = 5;
   localparam int BUCKET_LO  = 4;
   localparam int FREQ_HI    = 3;
   localparam int FREQ_LO    = 0;
   localparam int MODE_HI    = 2;
   localparam int MODE_LO    = 0;

   // frequency codes: 8 is a hole, above 10 unused
   localparam logic [FREQ_W-1:0] FREQ_CODE_8K   = 4'h0;
   localparam logic [FREQ_W-1:0] FREQ_CODE_RSVD = 4'h8;
   localparam logic [FREQ_W-1:0] FREQ_CODE_MAX  = 4'ha;

   typedef enum logic [MODE_W-1:0] {
      LOOP_AUTO        = 3'b000,
      LOOP_FREE_RUN    = 3'b001,
      LOOP_HOLDOVER    = 3'b010,
      LOOP_UNUSED      = 3'b011,
      LOOP_LOCKED      = 3'b100,
      LOOP_PRE_LOCKED2 = 3'b101,
      LOOP_PRE_LOCKED  = 3'b110,
      LOOP_PHASE_LOST  = 3'b111
   } irmc_loop_state_t;

   function automatic logic irmcFreqUnused(input logic [FREQ_W-1:0] code);
      irmcFreqUnused = (code == FREQ_CODE_RSVD) || (code > FREQ_CODE_MAX);
   endfunction

endpackage

/* File: logic/irmc_reg_if.sv */
// carrier between the register bank and one input configuration register
`timescale 1ns/100ps
interface irmc_reg_if;
   import irmc_pkg::*;
   logic              wrEn;
   logic [DATA_W-1:0] wrData;
   logic [DATA_W-1:0] word;
   logic              freqUnused;

   modport owner (input wrEn, input wrData, output word, output freqUnused);
   modport bank  (output wrEn, output wrData, input word, input freqUnused);
endinterface

/* File: logic/irmc_top.sv */
// register bank for reference input and main loop mode configuration
`timescale 1ns/100ps
module irmc_top
#(
   parameter int NUM_INPUTS = irmc_pkg::NUM_INPUTS
)
(
   input  wire logic                                      clk_sys,
   input  wire logic                                      rst,
   input  wire logic                                      cfgWrEn,
   input  wire logic                                      cfgRdEn,
   input  wire logic [irmc_pkg::ADDR_W-1:0]               cfgAddr,
   input  wire logic [irmc_pkg::DATA_W-1:0]               cfgWrData,
   output logic      [irmc_pkg::DATA_W-1:0]               cfgRdData,
   output logic                                           cfgRdValid,
   output logic      [NUM_INPUTS-1:0]                     inputPredivideSelect,
   output logic      [NUM_INPUTS-1:0]                     lockAt8kSelect,
   output logic      [irmc_pkg::BUCKET_W*NUM_INPUTS-1:0]  activityBucketSelect,
   output logic      [irmc_pkg::FREQ_W*NUM_INPUTS-1:0]    inputFrequencyCode,
   output logic      [NUM_INPUTS-1:0]                     inputFreqCodeUnused,
   output irmc_pkg::irmc_loop_state_t                     mainLoopForcedState,
   output logic                                           mainLoopAutomatic,
   output logic                                           mainLoopForceActive
);
   import irmc_pkg::*;

   // ******************************************************************
   // elaboration check
   // ******************************************************************
   if (NUM_INPUTS != irmc_pkg::NUM_INPUTS)
   begin : gBadCount
      $error("irmc_top: input count must match the register map");
   end

   logic [DATA_W-1:0] inWord [NUM_INPUTS];
   logic [NUM_INPUTS-1:0] inWrHit;

   // ******************************************************************
   // per-input configuration registers
   // ******************************************************************
   for (genvar i = 0; i < NUM_INPUTS; i++)
   begin : gInput
      irmc_reg_if regIf ();

      assign inWrHit[i]     = cfgWrEn && (cfgAddr == INPUT_CFG_ADDR[i]);
      assign regIf.wrEn     = inWrHit[i];
      assign regIf.wrData   = cfgWrData;
      assign inWord[i]      = regIf.word;

      irmc_input_cfg #(
         .RESET_VALUE (INPUT_CFG_RESET[i])
      ) uCfg (
         .clk_sys (clk_sys),
         .rst     (rst),
         .cfgPort (regIf.owner)
      );

      // field routing to the loop, monitors and pre-dividers
      assign inputPredivideSelect[i] = regIf.word[PREDIV_BIT];
      assign lockAt8kSelect[i]       = regIf.word[LOCK8K_BIT];
      assign activityBucketSelect[BUCKET_W*i +: BUCKET_W] =
         regIf.word[BUCKET_HI:BUCKET_LO];
      assign inputFrequencyCode[FREQ_W*i +: FREQ_W] =
         regIf.word[FREQ_HI:FREQ_LO];
      assign inputFreqCodeUnused[i]  = regIf.freqUnused;
   end

   // ******************************************************************
   // loop state force register
   // ******************************************************************
   irmc_loop_state_t forceState_r;
   irmc_loop_state_t forceState_nxt;
   logic             auto_r;
   logic             auto_nxt;
   logic             active_r;
   logic             active_nxt;

   always_comb
   begin
      forceState_nxt = forceState_r;
      if (cfgWrEn && (cfgAddr == LOOP_FORCE_ADDR))
      begin
         // only the mode field is stored
         forceState_nxt = irmc_loop_state_t'(cfgWrData[MODE_HI:MODE_LO]);
      end
      auto_nxt   = 1'b0;
      active_nxt = 1'b0;
      case (forceState_nxt)
         LOOP_AUTO:   auto_nxt   = 1'b1;
         LOOP_UNUSED: active_nxt = 1'b0;
         default:     active_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         forceState_r <= irmc_loop_state_t'(LOOP_FORCE_RESET);
         auto_r       <= 1'b1;
         active_r     <= 1'b0;
      end
      else
      begin
         forceState_r <= forceState_nxt;
         auto_r       <= auto_nxt;
         active_r     <= active_nxt;
      end
   end

   assign mainLoopForcedState = forceState_r;
   assign mainLoopAutomatic   = auto_r;
   assign mainLoopForceActive = active_r;

   // ******************************************************************
   // read port
   // ******************************************************************
   logic [DATA_W-1:0] rdData_r;
   logic [DATA_W-1:0] rdData_nxt;
   logic              rdValid_r;
   logic              rdValid_nxt;

   always_comb
   begin
      rdValid_nxt = cfgRdEn;
      rdData_nxt  = rdData_r;
      if (cfgRdEn)
      begin
         if (cfgAddr == INPUT_CFG_ADDR[0])
            rdData_nxt = inWord[0];
         else if (cfgAddr == INPUT_CFG_ADDR[1])
            rdData_nxt = inWord[1];
         else if (cfgAddr == INPUT_CFG_ADDR[2])
            rdData_nxt = inWord[2];
         else if (cfgAddr == INPUT_CFG_ADDR[3])
            rdData_nxt = inWord[3];
         else if (cfgAddr == LOOP_FORCE_ADDR)
            rdData_nxt = {{(DATA_W-MODE_W){1'b0}}, forceState_r};
         else
            rdData_nxt = UNMAPPED_READ;
      end
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         rdData_r  <= UNMAPPED_READ;
         rdValid_r <= 1'b0;
      end
      else
      begin
         rdData_r  <= rdData_nxt;
         rdValid_r <= rdValid_nxt;
      end
   end

   assign cfgRdData  = rdData_r;
   assign cfgRdValid = rdValid_r;

   // ******************************************************************
   // checks
   // ******************************************************************
   default clocking cbSys @(posedge clk_sys); endclocking
   default disable iff (rst);

   for (genvar k = 0; k < NUM_INPUTS; k++)
   begin : gChk
      chk_predivide_route: assert property (
         inWrHit[k] |=> inputPredivideSelect[k]
            == $past(cfgWrData[PREDIV_BIT]))
         else $error("pre-divide select did not follow write");
      chk_lock8k_route: assert property (
         inWrHit[k] |=> lockAt8kSelect[k] == $past(cfgWrData[LOCK8K_BIT]))
         else $error("8 kHz lock select did not follow write");
      chk_bucket_select: assert property (
         inWrHit[k] |=> activityBucketSelect[BUCKET_W*k +: BUCKET_W]
            == $past(cfgWrData[BUCKET_HI:BUCKET_LO]))
         else $error("bucket select did not follow write");
      chk_freq_unused_flag: assert property (
         inWrHit[k] |=> inputFreqCodeUnused[k]
            == irmcFreqUnused($past(cfgWrData[FREQ_HI:FREQ_LO])))
         else $error("unused frequency flag wrong");
      chk_input_reset_value: assert property (
         $past(rst) |-> inWord[k] == INPUT_CFG_RESET[k])
         else $error("input register reset value wrong");
      chk_word_holds: assert property (
         !inWrHit[k] |=> $stable(inWord[k]))
         else $error("input register changed without write");
   end

   chk_auto_mode: assert property (
      cfgWrEn && cfgAddr == LOOP_FORCE_ADDR
         && cfgWrData[MODE_HI:MODE_LO] == LOOP_AUTO
      |=> mainLoopAutomatic && !mainLoopForceActive)
      else $error("automatic mode not selected");
   chk_force_locked: assert property (
      cfgWrEn && cfgAddr == LOOP_FORCE_ADDR
         && cfgWrData[MODE_HI:MODE_LO] == LOOP_LOCKED
      |=> mainLoopForcedState == LOOP_LOCKED && mainLoopForceActive
         ##1 (mainLoopForceActive || $past(cfgWrEn)))
      else $error("locked state not forced");
   chk_unused_code: assert property (
      mainLoopForcedState == LOOP_UNUSED |-> !mainLoopForceActive
         && !mainLoopAutomatic)
      else $error("unused force code acted");
   chk_mode_read_zero: assert property (
      cfgRdEn && cfgAddr == LOOP_FORCE_ADDR
      |=> cfgRdValid && cfgRdData[DATA_W-1:MODE_W] == '0
         && cfgRdData[MODE_HI:MODE_LO] == $past(forceState_r))
      else $error("mode register read back wrong");
   chk_force_stored: assert property (
      cfgWrEn && cfgAddr == LOOP_FORCE_ADDR
      |=> mainLoopForcedState == $past(cfgWrData[MODE_HI:MODE_LO]))
      else $error("mode field not stored");
   chk_force_holds: assert property (
      !(cfgWrEn && cfgAddr == LOOP_FORCE_ADDR)
      |=> $stable(mainLoopForcedState))
      else $error("mode field changed without write");
   chk_force_reset: assert property (
      $past(rst) |-> mainLoopAutomatic && !mainLoopForceActive
         && mainLoopForcedState == LOOP_AUTO)
      else $error("mode register reset value wrong");
endmodule

/* File: test/irmc_host_model.sv */
// host software model driving the configuration register port
`timescale 1ns/100ps
module irmc_host_model
(
   input  wire logic       clk_sys,
   output logic            cfgWrEn,
   output logic            cfgRdEn,
   output logic [7:0]      cfgAddr,
   output logic [7:0]      cfgWrData,
   input  wire logic [7:0] cfgRdData,
   input  wire logic       cfgRdValid
);
   initial
   begin
      cfgWrEn = 1'b0;
      cfgRdEn = 1'b0;
      cfgAddr = 8'h00;
      cfgWrData = 8'h00;
   end

   // released lines show the inverse, never the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      cfgWrEn = 1'b1;
      cfgAddr = a;
      cfgWrData = d;
      @(negedge clk_sys);
      cfgWrEn = 1'b0;
      cfgAddr = ~a;
      cfgWrData = ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(negedge clk_sys);
      cfgRdEn = 1'b1;
      cfgAddr = a;
      @(negedge clk_sys);
      cfgRdEn = 1'b0;
      cfgAddr = ~a;
      d = cfgRdData;
      v = cfgRdValid;
   endtask
endmodule

/* File: test/tb_top.sv */
// self-checking testbench for the input and loop mode register bank
`timescale 1ns/100ps
module tb_top;
   import irmc_pkg::*;
   logic             clk_sys;
   logic             rst;
   logic             cfgWrEn;
   logic             cfgRdEn;
   logic [7:0]       cfgAddr;
   logic [7:0]       cfgWrData;
   logic [7:0]       cfgRdData;
   logic             cfgRdValid;
   logic [3:0]       pre;
   logic [3:0]       lock;
   logic [7:0]       bucket;
   logic [15:0]      freq;
   logic [3:0]       unused;
   irmc_loop_state_t loopState;
   logic             loopAuto;
   logic             loopForce;
   int               miscompares = 0;
   int               comparisons = 0;
   int               cycles = 0;
   logic [7:0]       rdVal;
   logic             rdOk;

   irmc_host_model i_irmc_host_model (.clk_sys(clk_sys), .cfgWrEn(cfgWrEn),
      .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid));
   irmc_top i_irmc_top (.clk_sys(clk_sys), .rst(rst), .cfgWrEn(cfgWrEn),
      .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
      .inputPredivideSelect(pre), .lockAt8kSelect(lock),
      .activityBucketSelect(bucket), .inputFrequencyCode(freq),
      .inputFreqCodeUnused(unused), .mainLoopForcedState(loopState),
      .mainLoopAutomatic(loopAuto), .mainLoopForceActive(loopForce));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic conclude();
      if (miscompares == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         miscompares++;
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      i_irmc_host_model.rd(a, rdVal, rdOk);
      chk({8'h00, rdVal}, {8'h00, exp});
      chk({15'h0000, rdOk}, 16'h0001);
   endtask

   // ********************************************************************
   // scenarios
   // ********************************************************************
   task automatic test_reset();
      logic [7:0] rv [4] = '{8'h00, 8'h00, 8'h03, 8'h03};
      chk({15'h0000, cfgRdValid}, 16'h0000);
      for (int i = 0; i < 4; i++)
         rdchk(INPUT_CFG_ADDR[i], rv[i]);
      rdchk(8'h32, 8'h00);
      chk(freq, 16'h3300);
      chk({pre, lock, bucket}, 16'h0000);
      chk({12'h000, unused}, 16'h0000);
      chk({12'h000, loopState, loopForce}, 16'h0000);
      chk({15'h0000, loopAuto}, 16'h0001);
   endtask

   task automatic test_fields();
      logic [7:0] v [4] = '{8'hc5, 8'h98, 8'h6f, 8'h3a};
      for (int i = 0; i < 4; i++)
         i_irmc_host_model.wr(INPUT_CFG_ADDR[i], v[i]);
      @(negedge clk_sys);
      chk({12'h000, pre}, 16'h0003);
      chk({12'h000, lock}, 16'h0005);
      chk({8'h00, bucket}, 16'h00e4);
      chk(freq, 16'haf85);
      chk({12'h000, unused}, 16'h0006);
      for (int i = 0; i < 4; i++)
         rdchk(INPUT_CFG_ADDR[i], v[i]);
      for (int c = 0; c < 16; c++)
      begin
         i_irmc_host_model.wr(8'h22, c[7:0]);
         @(negedge clk_sys);
         chk({15'h0000, unused[0]}, {15'h0000, c == 8 || c > 10});
      end
   endtask

   task automatic test_mode();
      for (int m = 0; m < 8; m++)
      begin
         i_irmc_host_model.wr(8'h32, 8'hf8 | m[7:0]);
         rdchk(8'h32, m[7:0]);
         chk({13'h0000, loopState}, m[15:0]);
         chk({15'h0000, loopAuto}, {15'h0000, m == 0});
         chk({15'h0000, loopForce}, {15'h0000, m != 0 && m != 3});
         @(negedge clk_sys);
         chk({7'h00, cfgRdValid, cfgRdData}, {8'h00, m[7:0]});
      end
   endtask

   task automatic test_unmapped_and_reset();
      i_irmc_host_model.wr(8'h24, 8'hff);
      rdchk(8'h24, 8'h00);
      chk({12'h000, pre}, 16'h0002);
      chk(freq, 16'haf8f);
      chk({13'h0000, loopState}, 16'h0007);
      @(negedge clk_sys);
      rst = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(freq, 16'h3300);
      chk({pre, lock, bucket}, 16'h0000);
      chk({12'h000, loopState, loopForce}, 16'h0000);
      chk({15'h0000, loopAuto}, 16'h0001);
      rst = 1'b0;
      rdchk(8'h22, 8'h00);
      rdchk(8'h28, 8'h03);
   endtask

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         conclude();
      end
   end

   initial
   begin
      rst = 1'b1;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      test_reset();
      test_fields();
      test_mode();
      test_unmapped_and_reset();
      conclude();
   end
endmodule
